/* tb/drv_fault_regs_bench.sv */
// Self-checking bench of the fault and status register bank
`timescale 1ns/10ps
`default_nettype none
module drv_fault_regs_bench import drv_regs_pkg::*; ();
    localparam logic [5:0] DEV = 6'h15; // Arbitrary value
    localparam logic [1:0] REV = 2'h2;  // Arbitrary value
    localparam reg8_t FO_EXP [7] = '{8'h30, 8'h28, 8'h24, 8'h24, 8'h22, 8'h21, 8'h20};
    localparam reg8_t DG_EXP [7] = '{8'h00, 8'h00, 8'h0A, 8'h05, 8'h00, 8'h00, 8'hC0};
    logic clk = 1'b0, rst = 1'b1, sclk, cs_n, sdi, sdo, sdo_oe, alert_n, dis_o, drv_o, locked;
    logic [6:0] det = 7'h00;   // Event inputs
    logic [4:0] live = 5'h10;  // {disable, drive, trip, active, comparator}
    logic [31:0] cfg;
    logic [31:0] seed = 32'h6CA6;
    logic [15:0] rx;
    int num_errors = 0, samples_checked = 0, cycles = 0;
    drv_fault_regs #(.DEV_CODE(DEV), .REV_CODE(REV)) drv_fault_regs_inst (
        .CORE_CLK_I(clk), .RESET_I(rst), .SPI_SCLK_I(sclk), .SPI_CS_N_I(cs_n),
        .SPI_SDI_I(sdi), .SPI_SDO_O(sdo), .SPI_SDO_OE_O(sdo_oe), .DISABLE_PAD_I(live[4]),
        .DRIVE_PAD_I(live[3]), .OVERVOLT_DET_I(det[6]), .UNDERVOLT_DET_I(det[5]),
        .HS_OVERCUR_DET_I(det[4]), .LS_OVERCUR_DET_I(det[3]), .THERMAL_DET_I(det[2]),
        .PUMP_UV_DET_I(det[1]), .OPEN_LOAD_DET_I(det[0]), .TRIP_LEVEL_I(live[2]),
        .ACTIVE_I(live[1]), .OFF_CMP_I(live[0]), .FAULT_ALERT_N_O(alert_n),
        .OUT_DISABLE_O(dis_o), .OUT_DRIVE_O(drv_o), .CFG_LOCKED_O(locked), .CONFIG_O(cfg));
    spi_host_model spi_host_model_inst (.clk_i(clk), .sdo_i(sdo_oe ? sdo : ~sdo),
        .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
    initial begin
        forever #5 clk = ~clk;
    end
    // Next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic check(input reg8_t got, input reg8_t exp);
        samples_checked++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check
    task automatic rchk(input addr_t a, input reg8_t exp);
        spi_host_model_inst.xfer({2'b01, a, 8'h00}, 16, rx);
        check(rx[7:0], exp);
    endtask : rchk
    task automatic wr(input addr_t a, input reg8_t d);
        spi_host_model_inst.xfer({2'b00, a, d}, 16, rx);
    endtask : wr
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, num_errors);
        if (num_errors == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : conclude
    // Cuts a hang short
    always @(negedge clk) begin
        cycles++;
        if (cycles == 30000) begin
            num_errors++;
            conclude();
        end
    end
    initial begin
        repeat (4) @(negedge clk);
        rst = 1'b0;
        repeat (3) @(negedge clk);
        rchk(ADDR_IDENT, {DEV, REV});
        rchk(ADDR_FAULT, RST_FAULT | 8'h20);
        rchk(ADDR_DIAG_A, 8'h00);
        rchk(ADDR_PAD_STAT, RST_PAD_STAT);
        rchk(ADDR_CMD, RST_CMD);
        rchk(ADDR_OVERRIDE, RST_OVERRIDE);
        rchk(6'h05, 8'h00);
        rchk(ADDR_FAULT, 8'hE0);
        wr(ADDR_CMD, 8'h80);
        rchk(ADDR_FAULT, 8'h00);
        check({7'h00, alert_n}, 8'h01);
        spi_host_model_inst.xfer(16'h0000, 12, rx);
        rchk(ADDR_FAULT, 8'hA0);
        check(rx[15:8], 8'hA1);
        wr(ADDR_CMD, 8'h80);
        $display("reset and error test done");
        // Each event alone sets its flags; live bits follow random levels
        for (int i = 0; i < 7; i++) begin
            seed = lfsr(seed);
            live = seed[4:0];
            det = 7'h40 >> i;
            @(negedge clk);
            det = 7'h00;
            rchk(ADDR_FAULT, FO_EXP[i]);
            rchk(ADDR_DIAG_A, DG_EXP[i] | {2'b00, live[2:1], 4'h0});
            rchk(ADDR_PAD_STAT, {live[4], 2'b00, live[1], 3'b000, live[0]});
            check({7'h00, alert_n}, 8'h00);
            wr(ADDR_CMD, 8'h80);
        end
        $display("event test done");
        wr(ADDR_OVERRIDE, 8'h01);
        rchk(ADDR_OVERRIDE, RST_OVERRIDE);
        check({6'h00, dis_o, drv_o}, {6'h00, live[4:3]});
        wr(ADDR_CMD, 8'h10);
        wr(ADDR_OVERRIDE, 8'h09);
        rchk(ADDR_OVERRIDE, 8'h0D);
        // Disable combines by AND, drive by OR at their reset selects
        for (int p = 0; p < 4; p++) begin
            live[4:3] = p[1:0];
            repeat (6) @(negedge clk);
            check({6'h00, dis_o, drv_o}, {6'h00, p[1], 1'b1});
        end
        wr(ADDR_CMD, 8'h02);
        wr(ADDR_CFG_BASE, 8'hFF);
        check({7'h00, locked}, 8'h01);
        check(cfg[7:0], 8'h10);
        rchk(ADDR_CMD, 8'h02);
        wr(ADDR_CMD, 8'h03);
        wr(ADDR_CFG_BASE, 8'hA5);
        check({7'h00, locked}, 8'h00);
        check(cfg[7:0], 8'hA5);
        // Threshold select 11b turns the overvoltage check off
        wr(ADDR_CFG_BASE, 8'hE5);
        check(cfg[7:0], 8'hE5);
        det = 7'h40;
        @(negedge clk);
        det = 7'h00;
        rchk(ADDR_FAULT, 8'h00);
        $display("lock test done");
        conclude();
    end
endmodule : drv_fault_regs_bench
`default_nettype wire

/* tb/spi_host_model.sv */
// Serial host model sending command and data frames to the bank
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    input  wire logic clk_i,  // Core clock, paces the serial clock
    input  wire logic sdo_i,  // Serial data from the device
    output logic      sclk_o, // Serial clock, idle low
    output logic      cs_n_o, // Chip select, low active
    output logic      sdi_o   // Serial data to the device
);
    initial begin
        sclk_o = 1'b0;
        cs_n_o = 1'b1;
        sdi_o = 1'b0;
    end
    // Shifts n bits MSB first, serial clock low for ten core cycles and high for five per bit
    task automatic xfer(input logic [15:0] f, input int n, output logic [15:0] rx);
        rx = 16'h0000;
        @(negedge clk_i);
        cs_n_o = 1'b0;
        for (int i = n - 1; i >= 0; i--) begin
            repeat (5) @(negedge clk_i);
            sdi_o = f[i];
            repeat (5) @(negedge clk_i);
            sclk_o = 1'b1;
            rx = {rx[14:0], sdo_i};
            repeat (5) @(negedge clk_i);
            sclk_o = 1'b0;
        end
        repeat (5) @(negedge clk_i);
        cs_n_o = 1'b1;
        sdi_o = ~sdi_o; // Released line keeps no stale level
        repeat (12) @(negedge clk_i);
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

/* verilog/drv_fault_regs.sv */
// Fault, status, command and pin override register bank of the half-bridge driver
// Behaviour
// - Comm error flag, bit 7, after bad frame
// - Power-on flag bit 6 resets to one
// - Bit 5 is OR of all faults
// - Overvoltage sets bit 4 unless disabled
// - Undervoltage sets bit 3
// - Any transistor overcurrent sets bit 2
// - Overtemperature sets bit 1
// - Pump undervoltage sets bit 0
// - Active open load sets bits 7 and 6
// - Trip level reached shows in bit 5
// - Active state in both status registers, bit 4
// - High-side overcurrent sets bits 3 and 1
// - Low-side overcurrent sets bits 2 and 0
// - Disable pad level in bit 7, reset one
// - Bit 0 shows off-state comparator live
// - Clear command clears faults, releases alert
// - Override lock: 10b unlocks, reset locked
// - Config lock: 10b locks, reset unlocked
// - Override bit 3 stands for disable pad
// - Override bit 0 stands for drive pad
// - Combine select: 0 OR, 1 AND
// - Unlisted address blocked and flags error
// - Unavailable bits read as zero
`timescale 1ns/10ps
`default_nettype none
module drv_fault_regs
    import drv_regs_pkg::*;
#(
    parameter logic [5:0] DEV_CODE = 6'h2C, // Arbitrary value
    parameter logic [1:0] REV_CODE = 2'h1   // Arbitrary value
) (
    input  wire logic        CORE_CLK_I,        // Core clock, 100 MHz
    input  wire logic        RESET_I,           // Asynchronous reset, high
    input  wire logic        SPI_SCLK_I,        // Serial clock pin
    input  wire logic        SPI_CS_N_I,        // Chip select pin, low active
    input  wire logic        SPI_SDI_I,         // Serial data in pin
    output logic             SPI_SDO_O,         // Serial data out
    output logic             SPI_SDO_OE_O,      // Serial data out enable
    input  wire logic        DISABLE_PAD_I,     // Output disable pad
    input  wire logic        DRIVE_PAD_I,       // Bridge drive pad
    input  wire logic        OVERVOLT_DET_I,    // Supply overvoltage detected
    input  wire logic        UNDERVOLT_DET_I,   // Supply undervoltage detected
    input  wire logic        HS_OVERCUR_DET_I,  // High-side overcurrent
    input  wire logic        LS_OVERCUR_DET_I,  // Low-side overcurrent
    input  wire logic        THERMAL_DET_I,     // Overtemperature
    input  wire logic        PUMP_UV_DET_I,     // Charge pump undervoltage
    input  wire logic        OPEN_LOAD_DET_I,   // Open load in active state
    input  wire logic        TRIP_LEVEL_I,      // Current regulation trip
    input  wire logic        ACTIVE_I,          // Device in active state
    input  wire logic        OFF_CMP_I,         // Off-state diagnostic comparator
    output logic             FAULT_ALERT_N_O,   // Fault alert pad, low active
    output logic             OUT_DISABLE_O,     // Effective disable level
    output logic             OUT_DRIVE_O,       // Effective drive level
    output logic             CFG_LOCKED_O,      // Configuration locked
    output logic [31:0]      CONFIG_O           // Configuration bytes 0Ah..0Dh
);
    frame_if fr ();

    logic [PAD_COUNT-1:0] pad_meta_q, pad_q;
    logic [FL_COUNT-1:0]  flag_q, flag_set;
    logic [1:0]           ovr_lock_q, cfg_lock_q;
    logic                 ovr_dis_q, ovr_drv_q, alert_n_q;
    logic [31:0]          cfg_q;
    logic [CFG_COUNT-1:0] cfg_we;
    logic [1:0]           eff_out;
    logic                 wr, clr, mapped, is_cfg, ovr_unlocked, cfg_locked, fault_any;
    logic                 ovr_we, cmd_we;
    logic [1:0]           cfg_idx;
    reg8_t                fault_view, diag_a, pad_stat, rdata;
    logic                 s_ov, s_uv, s_hs, s_ls, s_th, s_pump, s_ola;
    logic                 s_trip, s_act, s_cmp, s_dis, s_drv;

    // Serial target decodes frames
    spi_frame_target u_link (
        .clk_i    (CORE_CLK_I),
        .rst_i    (RESET_I),
        .sclk_i   (SPI_SCLK_I),
        .cs_n_i   (SPI_CS_N_I),
        .sdi_i    (SPI_SDI_I),
        .sdo_o    (SPI_SDO_O),
        .sdo_oe_o (SPI_SDO_OE_O),
        .fr       (fr.link_side)
    );

    // Two-stage synchroniser on every pad and detector input
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            pad_meta_q <= PAD_SYNC_RESET;
            pad_q      <= PAD_SYNC_RESET;
        end else begin
            pad_meta_q <= {DISABLE_PAD_I, DRIVE_PAD_I, OVERVOLT_DET_I, UNDERVOLT_DET_I,
                           HS_OVERCUR_DET_I, LS_OVERCUR_DET_I, THERMAL_DET_I,
                           PUMP_UV_DET_I, OPEN_LOAD_DET_I, TRIP_LEVEL_I, ACTIVE_I,
                           OFF_CMP_I};
            pad_q      <= pad_meta_q;
        end
    end
    assign {s_dis, s_drv, s_ov, s_uv, s_hs, s_ls, s_th, s_pump, s_ola, s_trip, s_act,
            s_cmp} = pad_q;

    // Frame decode
    assign wr      = fr.valid & ~fr.read;
    assign is_cfg  = (fr.addr >= ADDR_CFG_BASE) &&
                     (fr.addr <  ADDR_CFG_BASE + 6'(CFG_COUNT));
    assign cfg_idx = 2'(fr.addr - ADDR_CFG_BASE);
    assign mapped  = (fr.addr <= ADDR_PAD_STAT) || (fr.addr == ADDR_CMD) ||
                     (fr.addr == ADDR_OVERRIDE) || is_cfg;
    assign cmd_we  = wr & mapped & (fr.addr == ADDR_CMD);
    assign clr     = cmd_we & fr.wdata[CMD_CLEAR];
    assign ovr_unlocked = (ovr_lock_q == LOCK_CODE);
    assign cfg_locked   = (cfg_lock_q == LOCK_CODE);
    assign ovr_we  = wr & (fr.addr == ADDR_OVERRIDE) & ovr_unlocked;

    // Hardware events feeding the sticky flags
    always_comb begin
        flag_set           = '0;
        flag_set[FL_COMM]  = fr.err | (fr.valid & ~mapped);
        flag_set[FL_OV]    = s_ov & (cfg_q[CFG1_OV_SEL_LSB +: 2] != OV_SEL_OFF);
        flag_set[FL_UV]    = s_uv;
        flag_set[FL_HS]    = s_hs;
        flag_set[FL_LS]    = s_ls;
        flag_set[FL_THERM] = s_th;
        flag_set[FL_PUMP]  = s_pump;
        flag_set[FL_OLA]   = s_ola;
    end

    // Sticky flags: a set in the clearing cycle wins
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) flag_q <= FLAG_RESET;
        else flag_q <= flag_set | (flag_q & ~{FL_COUNT{clr}});
    end

    // Lock fields and override bits
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) begin
            ovr_lock_q <= LOCK_RESET;
            cfg_lock_q <= LOCK_RESET;
            ovr_dis_q  <= RST_OVERRIDE[OVR_DISABLE];
            ovr_drv_q  <= RST_OVERRIDE[OVR_DRIVE];
        end else begin
            if (cmd_we) begin
                ovr_lock_q <= fr.wdata[CMD_OVR_LSB +: 2];
                cfg_lock_q <= fr.wdata[CMD_CFG_LSB +: 2];
            end
            if (ovr_we) begin
                ovr_dis_q <= fr.wdata[OVR_DISABLE];
                ovr_drv_q <= fr.wdata[OVR_DRIVE];
            end
        end
    end

    // Configuration bytes, write-protected while locked
    for (genvar g = 0; g < CFG_COUNT; g++) begin : g_cfg
        assign cfg_we[g] = wr & is_cfg & (cfg_idx == 2'(g)) & ~cfg_locked;
        always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
            if (RESET_I) cfg_q[g*8 +: 8] <= CFG_RESET[g*8 +: 8];
            else if (cfg_we[g]) cfg_q[g*8 +: 8] <= fr.wdata & CFG_MASK[g*8 +: 8];
        end
    end

    // Read views of the status registers
    assign fault_any  = |flag_q;
    assign fault_view = {flag_q[FL_COMM], flag_q[FL_POR], fault_any, flag_q[FL_OV],
                         flag_q[FL_UV], flag_q[FL_HS] | flag_q[FL_LS],
                         flag_q[FL_THERM], flag_q[FL_PUMP]};
    assign diag_a     = {flag_q[FL_OLA], flag_q[FL_OLA], s_trip, s_act,
                         flag_q[FL_HS], flag_q[FL_LS], flag_q[FL_HS], flag_q[FL_LS]};
    assign pad_stat   = {s_dis, 2'h0, s_act, 3'h0, s_cmp};

    // Read data selection
    always_comb begin
        case (fr.addr)
            ADDR_IDENT:    rdata = {DEV_CODE, REV_CODE};
            ADDR_FAULT:    rdata = fault_view;
            ADDR_DIAG_A:   rdata = diag_a;
            ADDR_PAD_STAT: rdata = pad_stat;
            ADDR_CMD:      rdata = {3'h0, ovr_lock_q, 1'b0, cfg_lock_q};
            ADDR_OVERRIDE: rdata = {4'h0, ovr_dis_q, OVR_FIXED, ovr_drv_q};
            default:       rdata = is_cfg ? cfg_q[cfg_idx*8 +: 8] : 8'h00;
        endcase
    end
    assign fr.rdata  = rdata;
    assign fr.status = {fault_view[7:1], flag_q[FL_COMM]};

    // Pad and register combine
    pad_combine u_pads (
        .clk_i      (CORE_CLK_I),
        .rst_i      (RESET_I),
        .unlocked_i (ovr_unlocked),
        .pad_i      ({s_dis, s_drv}),
        .reg_i      ({ovr_dis_q, ovr_drv_q}),
        .and_sel_i  ({cfg_q[CFG4_DIS_SEL], cfg_q[CFG4_DRV_SEL]}),
        .out_o      (eff_out)
    );

    // Alert pad follows the aggregate fault flag
    always_ff @(posedge CORE_CLK_I or posedge RESET_I) begin
        if (RESET_I) alert_n_q <= 1'b0;
        else alert_n_q <= ~fault_any;
    end

    assign FAULT_ALERT_N_O = alert_n_q;
    assign OUT_DISABLE_O   = eff_out[1];
    assign OUT_DRIVE_O     = eff_out[0];
    assign CFG_LOCKED_O    = cfg_locked;
    assign CONFIG_O        = cfg_q;

    default clocking cb @(posedge CORE_CLK_I); endclocking
    default disable iff (RESET_I);

    sequence clear_cmd_s;
        clr && (flag_set == '0);
    endsequence
    sequence cmd_write_s;
        cmd_we;
    endsequence

    comm_err_set_a: assert property (fr.err |=> fault_view[7])
        else $error("comm error flag not set after bad frame");
    por_clear_a: assert property (clear_cmd_s |=> !fault_view[6])
        else $error("power-on flag survives clear");
    fault_any_a: assert property (|flag_q |-> fault_view[FO_ANY] ##1 !FAULT_ALERT_N_O)
        else $error("aggregate fault or alert missing");
    ov_set_a: assert property (s_ov && cfg_q[6:5] != OV_SEL_OFF |=> fault_view[4])
        else $error("overvoltage flag not set");
    ov_off_a: assert property (cfg_q[6:5] == OV_SEL_OFF && !fault_view[4] |=>
        !fault_view[4]) else $error("disabled overvoltage check set flag");
    uv_set_a: assert property ($rose(s_uv) |=> fault_view[3])
        else $error("undervoltage flag not set");
    oc_set_a: assert property (s_hs || s_ls |=> fault_view[FO_OC])
        else $error("overcurrent flag not set");
    thermal_set_a: assert property (s_th && clr |=> fault_view[1])
        else $error("thermal event lost to clear");
    pump_set_a: assert property (s_pump |=> fault_view[0])
        else $error("pump undervoltage flag not set");
    ola_pair_a: assert property (s_ola |=> diag_a[7] && diag_a[6])
        else $error("open load bits not both set");
    trip_live_a: assert property (diag_a[5] == s_trip)
        else $error("trip level bit not live");
    active_mirror_a: assert property (diag_a[4] == pad_stat[4] && diag_a[4] == s_act)
        else $error("active bit copies differ");
    hs_pair_a: assert property (s_hs |=> diag_a[3] && diag_a[1])
        else $error("high-side overcurrent bits not set");
    ls_pair_a: assert property (s_ls |=> diag_a[2] && diag_a[0])
        else $error("low-side overcurrent bits not set");
    pad_level_a: assert property (pad_stat[7] == s_dis)
        else $error("disable pad level not shown");
    off_cmp_a: assert property (pad_stat[0] == s_cmp)
        else $error("comparator bit not live");
    clear_alert_a: assert property (clear_cmd_s |=> (flag_q == '0) ##1 FAULT_ALERT_N_O)
        else $error("clear did not release alert");
    ovr_lock_a: assert property (cmd_write_s |=>
        ovr_unlocked == ($past(fr.wdata[4:3]) == LOCK_CODE))
        else $error("override lock decode wrong");
    cfg_lock_a: assert property (cmd_write_s |=>
        cfg_locked == ($past(fr.wdata[1:0]) == LOCK_CODE))
        else $error("config lock decode wrong");
    unmapped_err_a: assert property (fr.valid && !mapped |=> fault_view[7])
        else $error("unlisted address not flagged");
    na_zero_a: assert property (fr.addr == ADDR_OVERRIDE |-> rdata[7:4] == 4'h0)
        else $error("unavailable bits not zero");
    cfg_locked_a: assert property (wr && is_cfg && cfg_locked |=> $stable(cfg_q))
        else $error("locked config was written");
    ovr_locked_a: assert property (wr && !ovr_unlocked |=> $stable({ovr_dis_q, ovr_drv_q}))
        else $error("locked override was written");
    ident_a: assert property (fr.addr == ADDR_IDENT |-> rdata == {DEV_CODE, REV_CODE})
        else $error("identity read wrong");
endmodule : drv_fault_regs
`default_nettype wire

/* verilog/drv_regs_pkg.sv */
// Register map, field positions and reset values of the driver status register bank
package drv_regs_pkg;
    typedef logic [7:0] reg8_t;
    typedef logic [5:0] addr_t;

    // Register offsets
    localparam addr_t ADDR_IDENT    = 6'h00;
    localparam addr_t ADDR_FAULT    = 6'h01;
    localparam addr_t ADDR_DIAG_A   = 6'h02;
    localparam addr_t ADDR_PAD_STAT = 6'h03;
    localparam addr_t ADDR_CMD      = 6'h08;
    localparam addr_t ADDR_OVERRIDE = 6'h09;
    localparam addr_t ADDR_CFG_BASE = 6'h0A;
    localparam int    CFG_COUNT     = 4;

    // Reset values
    localparam reg8_t RST_FAULT    = 8'h40;
    localparam reg8_t RST_PAD_STAT = 8'h80;
    localparam reg8_t RST_CMD      = 8'h09;
    localparam reg8_t RST_OVERRIDE = 8'h0C;
    localparam logic [31:0] CFG_RESET = {8'h04, 8'h40, 8'h00, 8'h10};
    localparam logic [31:0] CFG_MASK  = {8'hDF, 8'hDF, 8'hE7, 8'hFF};

    // Sticky flag vector positions, laid out as in the fault overview byte except open load (5) and low side (8)
    localparam int FL_COMM   = 7;
    localparam int FL_POR    = 6;
    localparam int FL_OLA    = 5;
    localparam int FL_OV     = 4;
    localparam int FL_UV     = 3;
    localparam int FL_HS     = 2;
    localparam int FL_THERM  = 1;
    localparam int FL_PUMP   = 0;
    localparam int FL_LS     = 8;
    localparam int FL_COUNT  = 9;
    localparam logic [8:0] FLAG_RESET = 9'h040;

    // Fault overview bit positions
    localparam int FO_ANY    = 5;
    localparam int FO_OC     = 2;

    // Command register fields
    localparam int CMD_CLEAR     = 7;
    localparam int CMD_OVR_LSB   = 3;
    localparam int CMD_CFG_LSB   = 0;
    localparam logic [1:0] LOCK_CODE  = 2'h2;
    localparam logic [1:0] LOCK_RESET = 2'h1;

    // Pin override register fields
    localparam int OVR_DISABLE = 3;
    localparam int OVR_DRIVE   = 0;
    localparam logic [1:0] OVR_FIXED = 2'h2;

    // Configuration fields steering the bank
    localparam int CFG1_OV_SEL_LSB = 5;
    localparam logic [1:0] OV_SEL_OFF = 2'h3;
    localparam int CFG4_DIS_SEL = 26;
    localparam int CFG4_DRV_SEL = 24;

    // Pad synchroniser order and reset
    localparam int PAD_COUNT = 12;
    localparam logic [11:0] PAD_SYNC_RESET = 12'h800;

    // Serial frame length
    localparam logic [4:0] FRAME_BITS = 5'h10;
    localparam logic [4:0] CMD_BITS   = 5'h08;
endpackage : drv_regs_pkg

/* verilog/frame_if.sv */
// Decoded serial frame passed between the serial target and the register bank
`timescale 1ns/10ps
`default_nettype none
interface frame_if;
    logic       valid;   // Complete well-formed frame, one cycle
    logic       err;     // Malformed frame, one cycle
    logic       read;    // Frame is a read
    logic [5:0] addr;    // Register offset
    logic [7:0] wdata;   // Write data
    logic [7:0] rdata;   // Read data of addr
    logic [7:0] status;  // First byte shifted out

    modport link_side (output valid, err, read, addr, wdata, input rdata, status);
    modport bank_side (input valid, err, read, addr, wdata, output rdata, status);
endinterface : frame_if
`default_nettype wire

/* verilog/pad_combine.sv */
// Merges the disable and drive pads with their register equivalents
`timescale 1ns/10ps
`default_nettype none
module pad_combine (
    input  wire logic       clk_i,      // Core clock
    input  wire logic       rst_i,      // Asynchronous reset
    input  wire logic       unlocked_i, // Override register unlocked
    input  wire logic [1:0] pad_i,      // {disable, drive} pads, synchronised
    input  wire logic [1:0] reg_i,      // {disable, drive} register bits
    input  wire logic [1:0] and_sel_i,  // 1 selects AND, 0 selects OR
    output logic      [1:0] out_o       // {disable, drive} effective levels
);
    logic [1:0] out_q, out_d;

    // Per channel combine, pads alone while locked
    for (genvar c = 0; c < 2; c++) begin : g_ch
        assign out_d[c] = !unlocked_i ? pad_i[c]
                        : and_sel_i[c] ? (pad_i[c] & reg_i[c])
                        : (pad_i[c] | reg_i[c]);
    end

    // Registered outputs, disabled at reset
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) out_q <= 2'h2;
        else out_q <= out_d;
    end
    assign out_o = out_q;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    combine_and_a: assert property (unlocked_i && and_sel_i[1] |=>
        out_o[1] == ($past(pad_i[1]) & $past(reg_i[1])))
        else $error("disable channel AND combine wrong");
    combine_or_a: assert property (unlocked_i && !and_sel_i[0] |=>
        out_o[0] == ($past(pad_i[0]) | $past(reg_i[0])))
        else $error("drive channel OR combine wrong");
    locked_pads_a: assert property (!unlocked_i |=> out_o == $past(pad_i))
        else $error("locked override still affects outputs");
endmodule : pad_combine
`default_nettype wire

/* verilog/spi_frame_target.sv */
// Oversampling serial target: 16-bit frames of command byte then data byte
`timescale 1ns/10ps
`default_nettype none
module spi_frame_target
    import drv_regs_pkg::*;
(
    input  wire logic    clk_i,    // Core clock
    input  wire logic    rst_i,    // Asynchronous reset
    input  wire logic    sclk_i,   // Serial clock pin
    input  wire logic    cs_n_i,   // Chip select pin, low active
    input  wire logic    sdi_i,    // Serial data in pin
    output logic         sdo_o,    // Serial data out
    output logic         sdo_oe_o, // Serial out enable
    frame_if.link_side   fr        // Decoded frame
);
    logic [2:0] meta_q, sync_q;
    logic       sck_prev_q, cs_prev_q, valid_q, err_q;
    logic [4:0] cnt_q;
    logic [7:0] rx_q, cmd_q, tx_q;
    logic       sck_rise, sck_fall, cs_fall, cs_rise, bad_frame;

    // Two-stage synchroniser on the three pins
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            meta_q <= 3'h2;
            sync_q <= 3'h2;
        end else begin
            meta_q <= {sdi_i, cs_n_i, sclk_i};
            sync_q <= meta_q;
        end
    end

    // Edge decode on synchronised pins
    assign sck_rise  = sync_q[0] & ~sck_prev_q & ~sync_q[1];
    assign sck_fall  = ~sync_q[0] & sck_prev_q & ~sync_q[1];
    assign cs_fall   = ~sync_q[1] & cs_prev_q;
    assign cs_rise   = sync_q[1] & ~cs_prev_q;
    assign bad_frame = (cnt_q != FRAME_BITS) | cmd_q[7];

    // Shift, count and frame end
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            sck_prev_q <= 1'b0;
            cs_prev_q  <= 1'b1;
            cnt_q      <= 5'h00;
            rx_q       <= 8'h00;
            cmd_q      <= 8'h00;
            tx_q       <= 8'h00;
            valid_q    <= 1'b0;
            err_q      <= 1'b0;
        end else begin
            sck_prev_q <= sync_q[0];
            cs_prev_q  <= sync_q[1];
            valid_q    <= cs_rise & ~bad_frame;
            err_q      <= cs_rise & bad_frame;
            if (cs_fall) begin
                cnt_q <= 5'h00;
                tx_q  <= fr.status;
            end else if (sck_rise) begin
                rx_q <= {rx_q[6:0], sync_q[2]};
                if (cnt_q == CMD_BITS - 5'h01) cmd_q <= {rx_q[6:0], sync_q[2]};
                if (cnt_q != 5'h1F) cnt_q <= cnt_q + 5'h01;
            end else if (sck_fall) begin
                tx_q <= (cnt_q == CMD_BITS) ? fr.rdata : {tx_q[6:0], 1'b0};
            end
        end
    end

    assign fr.valid  = valid_q;
    assign fr.err    = err_q;
    assign fr.read   = cmd_q[6];
    assign fr.addr   = cmd_q[5:0];
    assign fr.wdata  = rx_q;
    assign sdo_o     = tx_q[7];
    assign sdo_oe_o  = ~sync_q[1];
endmodule : spi_frame_target
`default_nettype wire
